/* File: tb_tbd_diag.sv */
// Self-checking testbench for the terminal bus diagnostic block
module tb_tbd_diag
   import tbd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk, rst, por, cyc, stb, we, ack, inj, link;
   logic [3:0]  adr;
   logic [31:0] wdat, rdat;
   logic [2:0]  inj_kind;
   logic [7:0]  inj_pos, inj_pas, ev, fpos, fpas, restarts;
   logic        cfg_chg, in_valid, fb_run, xlink, run_led, err_led, link_led, restart, act;
   logic [4:0]  lvl;
   int          n_fail;
   int          checks_done;
   // Short timings so whole flash sequences fit in the run
   localparam int unsigned T_FAST = 4;
   localparam int unsigned T_SLOW = 10;
   localparam int unsigned T_DARK = 20;
   localparam int unsigned T_HOLD = 40;

   tbd_chain_model chain (.clk_i(clk), .rst_i(rst), .inj_i(inj), .inj_kind_i(inj_kind), .inj_pos_i(inj_pos),
      .inj_pas_i(inj_pas), .link_i(link), .bus_restart_i(restart), .ev_o(ev), .fault_pos_o(fpos),
      .passive_cnt_o(fpas), .xbus_link_o(xlink), .restarts_o(restarts));

   tbd_diag #(.FAST_CYC(T_FAST), .SLOW_CYC(T_SLOW), .DARK_CYC(T_DARK), .HOLD_CYC(T_HOLD))
   dut (.clk_i(clk), .rst_i(rst), .por_i(por), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ev_cmd_err_i(ev[0]), .ev_data_err_i(ev[1]), .ev_reg_err_i(ev[2]), .ev_init_err_i(ev[3]),
      .ev_int_err_i(ev[4]), .ev_int_alt_i(ev[5]), .ev_len_err_i(ev[6]), .ev_emc_i(ev[7]),
      .fault_pos_i(fpos), .passive_cnt_i(fpas), .cfg_changed_i(cfg_chg), .inputs_valid_i(in_valid),
      .in_pending_i(lvl[0]), .out_pending_i(lvl[1]), .wdog_i(lvl[2]), .acyclic_i(lvl[3]),
      .async_cycle_i(lvl[4]), .fieldbus_run_i(fb_run), .xbus_link_i(xlink), .xbus_act_i(act),
      .run_led_o(run_led), .err_led_o(err_led), .link_led_o(link_led), .bus_restart_o(restart));

   always #50 clk = ~clk;

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Classic single cycle; no fixed latency assumed, only a bounded wait
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 16);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 16)
      begin
         n_fail++;
         $display("MISMATCH t=%0t bus answer missing", $time);
      end
   endtask

   task automatic inject(input logic [2:0] k, input logic [7:0] p, input logic [7:0] s);
      @(posedge clk);
      inj      <= 1'b1;
      inj_kind <= k;
      inj_pos  <= p;
      inj_pas  <= s;
      @(posedge clk);
      inj <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic por_pulse;
      @(posedge clk);
      por <= 1'b1;
      @(posedge clk);
      por <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic t_idle;
      logic [31:0] q;
      wb(ADDR_STATE, 1'b0, 32'h0, q);
      chk_word(q[15:0], STATE_RESET, "status after reset");
      wb(4'hC, 1'b0, 32'h0, q);
      chk_word(q[15:0], 16'h0000, "unmapped read");
      in_valid <= 1'b1;
      fb_run   <= 1'b1;
      wb(ADDR_STATE, 1'b1, 32'h0000FFFF, q);
      repeat (3) @(posedge clk);
      wb(ADDR_STATE, 1'b0, 32'h0, q);
      chk_word(q[15:0], 16'h0000, "status healthy");
      chk_bit(run_led, 1'b1, "run lamp healthy");
      chk_bit(err_led, 1'b0, "fault lamp healthy");
      $display("test idle done");
   endtask

   task automatic t_status;
      logic [31:0] q;
      logic [15:0] e [5] = '{16'h0200, 16'h0400, 16'h0800, 16'h8000, 16'h0001};
      for (int i = 0; i < 5; i++)
      begin
         lvl <= 5'h01 << i;
         repeat (3) @(posedge clk);
         wb(ADDR_STATE, 1'b0, 32'h0, q);
         chk_word(q[15:0], e[i], "status level bit");
      end
      lvl     <= 5'h00;
      cfg_chg <= 1'b1;
      @(posedge clk);
      cfg_chg <= 1'b0;
      repeat (4) @(posedge clk);
      wb(ADDR_STATE, 1'b0, 32'h0, q);
      chk_word(q[15:0], 16'h0002, "config change latched");
      wb(ADDR_CTRL, 1'b1, 32'h1, q);
      repeat (3) @(posedge clk);
      wb(ADDR_STATE, 1'b0, 32'h0, q);
      chk_word(q[15:0], 16'h0000, "config change cleared");
      fb_run <= 1'b0;
      repeat (4) @(posedge clk);
      chk_bit(run_led, 1'b0, "run lamp without fieldbus");
      fb_run <= 1'b1;
      $display("test status done");
   endtask

   task automatic t_code(input logic [2:0] k, input logic [7:0] p, input logic [7:0] s, input logic [3:0] c,
                         input logic [7:0] a, input logic sticky);
      logic [31:0] q;
      logic [7:0]  r0;
      logic [15:0] e;
      e = {1'b0, sticky, 1'b1, 1'b0, c, a};
      inject(k, p, s);
      wb(ADDR_CODE, 1'b0, 32'h0, q);
      chk_word(q[15:0] & 16'hEFFF, e, "fault code");
      chk_bit(run_led, 1'b0, "run lamp in fault");
      wb(ADDR_STATE, 1'b0, 32'h0, q);
      chk_word(q[15:0], (k == 3'd6) ? 16'h0005 : 16'h0001, "status in fault");
      inject((k == 3'd2) ? 3'd0 : 3'd2, 8'd9, 8'd0);
      wb(ADDR_CODE, 1'b0, 32'h0, q);
      chk_word(q[15:0] & 16'hEFFF, e, "first fault kept");
      r0 = restarts;
      wb(ADDR_CTRL, 1'b1, 32'h1, q);
      repeat (4) @(posedge clk);
      wb(ADDR_CODE, 1'b0, 32'h0, q);
      chk_bit(q[13], sticky, "latch after reset request");
      if (!sticky)
         chk_word({8'h00, restarts}, {8'h00, r0 + 8'h01}, "bus restarted");
      por_pulse();
      wb(ADDR_CODE, 1'b0, 32'h0, q);
      chk_bit(q[13], 1'b0, "cleared by power cycle");
      chk_bit(err_led, 1'b0, "fault lamp dark again");
      $display("test code %0d done", c);
   endtask

   // One full sequence, split at its long dark spans
   task automatic t_flash;
      int ph = 0, hi = 0, lo = 0, nf = 0, ns = 0, na = 0, nx = 0;
      inject(3'd2, 8'd3, 8'd1);
      for (int n = 0; n < 2000 && ph < 4; n++)
      begin
         @(posedge clk);
         if (err_led === 1'b1)
         begin
            if (lo > T_SLOW)
               ph++;
            lo = 0;
            hi++;
         end
         else
         begin
            if (hi == T_FAST && ph == 2)
               nf++;
            else if (hi == T_SLOW && ph == 2)
               ns++;
            else if (hi == T_SLOW && ph == 3)
               na++;
            else if (hi != 0 && ph >= 2)
               nx++;
            hi = 0;
            lo++;
         end
      end
      chk_word(16'(ph), 16'd4, "sequence repeated");
      chk_word(16'(nf), 16'(START_FLASHES), "fast start flashes");
      chk_word(16'(ns), 16'(CODE_REG), "slow code pulses");
      chk_word(16'(na), 16'd2, "slow argument pulses");
      chk_word(16'(nx), 16'd0, "other flash length");
      por_pulse();
      chk_bit(err_led, 1'b0, "lamp dark after power cycle");
      $display("test flash done");
   endtask

   task automatic t_emc;
      logic [31:0] q;
      int          n = 0;
      logic        prev;
      inject(3'd7, 8'd0, 8'd0);
      wb(ADDR_CODE, 1'b0, 32'h0, q);
      chk_bit(q[15], 1'b1, "interference flashing");
      prev = err_led;
      repeat (8 * T_FAST)
      begin
         @(posedge clk);
         n += (err_led != prev);
         prev = err_led;
      end
      chk_word(16'(n), 16'd8, "interference flash rate");
      por_pulse();
      wb(ADDR_CODE, 1'b0, 32'h0, q);
      chk_bit(q[15], 1'b0, "interference cleared");
      chk_bit(err_led, 1'b0, "lamp dark after interference");
      $display("test interference done");
   endtask

   task automatic t_link;
      int   n = 0;
      logic prev;
      @(posedge clk);
      link <= 1'b0;
      repeat (6) @(posedge clk);
      chk_bit(link_led, 1'b0, "link lamp unconnected");
      link <= 1'b1;
      repeat (6) @(posedge clk);
      chk_bit(link_led, 1'b1, "link lamp idle");
      act <= 1'b1;
      @(posedge clk);
      act <= 1'b0;
      repeat (4) @(posedge clk);
      prev = link_led;
      repeat (8 * T_FAST)
      begin
         @(posedge clk);
         n += (link_led != prev);
         prev = link_led;
      end
      chk_word(16'(n), 16'd8, "link lamp traffic");
      repeat (T_HOLD) @(posedge clk);
      chk_bit(link_led, 1'b1, "link lamp idle again");
      $display("test link done");
   endtask

   initial
   begin
      {clk, por, cyc, stb, we, inj, link, cfg_chg, in_valid, fb_run, act} = '0;
      {adr, wdat, inj_kind, inj_pos, inj_pas, lvl, n_fail, checks_done} = '0;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_idle();
      t_status();
      t_code(3'd0, 8'd5, 8'd1, CODE_CMD, 8'h00, 1'b0);
      t_code(3'd1, 8'd6, 8'd2, CODE_DATA, 8'h04, 1'b0);
      t_code(3'd1, 8'd0, 8'd0, CODE_DATA, 8'h00, 1'b0);
      t_code(3'd2, 8'd3, 8'd0, CODE_REG, 8'h03, 1'b0);
      t_code(3'd3, 8'd0, 8'd0, CODE_INT, 8'h00, 1'b1);
      t_code(3'd4, 8'd0, 8'd0, CODE_INT, ARG_INT_DATA, 1'b1);
      t_code(3'd5, 8'd0, 8'd0, CODE_INT, ARG_INT_DATA2, 1'b1);
      t_code(3'd6, 8'd0, 8'd0, CODE_LEN, 8'h00, 1'b0);
      t_flash();
      t_emc();
      t_link();
      report_and_stop();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      report_and_stop();
   end
endmodule // tb_tbd_diag

/* File: tbd_chain_model.sv */
// Behavioural chain of attached terminal modules for the diagnostic block
module tbd_chain_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Commands from the bench
   input  wire logic       inj_i,
   input  wire logic [2:0] inj_kind_i,
   input  wire logic [7:0] inj_pos_i,
   input  wire logic [7:0] inj_pas_i,
   input  wire logic       link_i,
   // Block side
   input  wire logic       bus_restart_i,
   output logic      [7:0] ev_o,
   output logic      [7:0] fault_pos_o,
   output logic      [7:0] passive_cnt_o,
   output logic            xbus_link_o,
   output logic      [7:0] restarts_o
);
   timeunit 1ns;
   timeprecision 1ns;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ev_o          <= 8'h00;
         fault_pos_o   <= 8'h00;
         passive_cnt_o <= 8'h00;
         restarts_o    <= 8'h00;
      end
      else
      begin
         // One-cycle event; position and passive count stay until the next fault
         ev_o <= inj_i ? (8'h01 << inj_kind_i) : 8'h00;
         if (inj_i)
         begin
            fault_pos_o   <= inj_pos_i;
            passive_cnt_o <= inj_pas_i;
         end
         if (bus_restart_i)
            restarts_o <= restarts_o + 8'h01;
      end
   end

   always_ff @(posedge clk_i)
      xbus_link_o <= link_i;
endmodule // tbd_chain_model

/* File: tbd_diag.sv */
// Terminal bus diagnostic lamps, fault flash code and status word
//
// Contract
// - Fault lamp dark without terminal error, flashes when one is detected.
// - Sequence: fast start burst, code pulses, dark pause, argument pulses.
// - Exactly two flash rates: fast for start, slow for counted pulses.
// - Argument pulse count equals position of last terminal before fault.
// - Passive terminals such as power feeds are skipped in that count.
// - Suspected interference gives continuous flashing instead of a code.
// - Bus command error shows code 3, argument 0.
// - Bus data error shows code 4, argument is break position.
// - Register communication failure with terminal n shows code 5, argument n.
// - Code 6: argument 0 init failure, 1 or 8 internal data error.
// - Process data length mismatch shows code 7, argument 0.
// - Some faults stay latched until power cycle of supply unit.
// - Green run lamp lit only when terminal bus and fieldbus both run.
// - Status word zero only when bus synchronous and error free.
// - Status bits 0 bus error, 1 config change, 2 length mismatch.
// - Status bits 8 no inputs, 9 input pending, 10 output pending.
// - Status bit 11 watchdog, bit 15 acyclic function active.
// - Device reset request clears latched bus error and restarts bus.
// - Link lamp off unconnected, on when idle, flashing with traffic.
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
module tbd_diag
   import tbd_pkg::*;
#(
   // Flash and activity timing in clock cycles
   parameter int unsigned FAST_CYC = FAST_HALF_CYC,
   parameter int unsigned SLOW_CYC = SLOW_HALF_CYC,
   parameter int unsigned DARK_CYC = PAUSE_CYC,
   parameter int unsigned HOLD_CYC = ACT_HOLD_CYC
)
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        por_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Terminal chain fault events, one-cycle pulses
   input  wire logic        ev_cmd_err_i,
   input  wire logic        ev_data_err_i,
   input  wire logic        ev_reg_err_i,
   input  wire logic        ev_init_err_i,
   input  wire logic        ev_int_err_i,
   input  wire logic        ev_int_alt_i,
   input  wire logic        ev_len_err_i,
   input  wire logic        ev_emc_i,
   input  wire logic [7:0]  fault_pos_i,
   input  wire logic [7:0]  passive_cnt_i,
   // Bus condition levels
   input  wire logic        cfg_changed_i,
   input  wire logic        inputs_valid_i,
   input  wire logic        in_pending_i,
   input  wire logic        out_pending_i,
   input  wire logic        wdog_i,
   input  wire logic        acyclic_i,
   input  wire logic        async_cycle_i,
   input  wire logic        fieldbus_run_i,
   // Expansion bus link pins
   input  wire logic        xbus_link_i,
   input  wire logic        xbus_act_i,
   // Lamps and bus restart
   output logic             run_led_o,
   output logic             err_led_o,
   output logic             link_led_o,
   output logic             bus_restart_o
);
   localparam logic [23:0] FAST_CNT  = 24'(FAST_CYC - 1);
   localparam logic [23:0] SLOW_CNT  = 24'(SLOW_CYC - 1);
   localparam logic [23:0] PAUSE_CNT = 24'(DARK_CYC - 1);
   localparam logic [23:0] ACT_CNT   = 24'(HOLD_CYC - 1);

   // Latched fault
   logic             err_q;
   logic             emc_q;
   logic             sticky_q;
   logic [3:0]       code_q;
   logic [7:0]       arg_q;
   logic             cfg_q;
   logic             reset_req;
   logic             new_err;
   logic [3:0]       new_code;
   logic [7:0]       new_arg;
   logic [7:0]       pos_active;

   // Wishbone
   logic             wb_req;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Write lands on the edge where the master sees ack
   assign reset_req = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0]
                      && wb_dat_i[CTRL_RESET_BIT];

   // Position of active terminal ahead of fault, passives excluded
   assign pos_active = (fault_pos_i > passive_cnt_i) ? fault_pos_i - passive_cnt_i : 8'h00;

   always_comb
   begin
      new_err  = 1'b1;
      new_code = 4'h0;
      new_arg  = 8'h00;
      if (ev_cmd_err_i)
      begin
         new_code = CODE_CMD;
      end
      else if (ev_data_err_i)
      begin
         new_code = CODE_DATA;
         new_arg  = pos_active;
      end
      else if (ev_reg_err_i)
      begin
         new_code = CODE_REG;
         new_arg  = pos_active;
      end
      else if (ev_init_err_i)
      begin
         new_code = CODE_INT;
      end
      else if (ev_int_err_i || ev_int_alt_i)
      begin
         new_code = CODE_INT;
         new_arg  = ev_int_alt_i ? ARG_INT_DATA2 : ARG_INT_DATA;
      end
      else if (ev_len_err_i)
      begin
         new_code = CODE_LEN;
      end
      else
      begin
         new_err = 1'b0;
      end
   end

   // First fault is kept; set wins over reset request
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         err_q    <= 1'b0;
         code_q   <= 4'h0;
         arg_q    <= 8'h00;
         sticky_q <= 1'b0;
      end
      else if (new_err && !err_q)
      begin
         err_q    <= 1'b1;
         code_q   <= new_code;
         arg_q    <= new_arg;
         sticky_q <= (new_code == CODE_INT);
      end
      else if (reset_req && !sticky_q && !new_err)
      begin
         err_q <= 1'b0;
      end
      else if (por_i)
      begin
         err_q    <= 1'b0;
         sticky_q <= 1'b0;
      end
   end

   // Interference only ends at power cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         emc_q <= 1'b0;
      else if (ev_emc_i)
         emc_q <= 1'b1;
      else if (por_i)
         emc_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cfg_q <= 1'b0;
      else if (cfg_changed_i)
         cfg_q <= 1'b1;
      else if (reset_req)
         cfg_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bus_restart_o <= 1'b0;
      else
         bus_restart_o <= reset_req;
   end

   // Status word
   logic [15:0] state_word;
   always_comb
   begin
      state_word               = 16'h0000;
      state_word[ST_BUS_ERR]   = err_q || async_cycle_i;
      state_word[ST_CFG_CHG]   = cfg_q;
      state_word[ST_LEN_ERR]   = err_q && (code_q == CODE_LEN);
      state_word[ST_NO_INPUTS] = !inputs_valid_i;
      state_word[ST_IN_PEND]   = in_pending_i;
      state_word[ST_OUT_PEND]  = out_pending_i;
      state_word[ST_WDOG]      = wdog_i;
      state_word[ST_ACYCLIC]   = acyclic_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i)
         begin
            case (wb_adr_i)
               ADDR_STATE: wb_dat_o <= {16'h0000, state_word};
               ADDR_CODE:  wb_dat_o <= {16'h0000, emc_q, sticky_q, err_q, 1'b0, code_q, arg_q};
               default:    wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Run lamp
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         run_led_o <= 1'b0;
      else
         run_led_o <= (state_word == 16'h0000) && fieldbus_run_i && !emc_q;
   end

   // Fault flash sequencer
   tbd_state_e  st_q;
   logic [23:0] tmr_q;
   logic [7:0]  cnt_q;
   logic        lamp_q;
   logic        tick;
   assign tick = (tmr_q == 24'h000000);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q   <= TBD_IDLE;
         tmr_q  <= 24'h000000;
         cnt_q  <= 8'h00;
         lamp_q <= 1'b0;
      end
      else if (emc_q && st_q != TBD_EMC)
      begin
         st_q   <= TBD_EMC;
         tmr_q  <= FAST_CNT;
         lamp_q <= 1'b1;
      end
      else if (!err_q && !emc_q)
      begin
         // Fault gone: stop mid-sequence so the lamp goes dark at once
         st_q   <= TBD_IDLE;
         tmr_q  <= 24'h000000;
         lamp_q <= 1'b0;
      end
      else if (!tick)
      begin
         tmr_q <= tmr_q - 24'h000001;
      end
      else
      begin
         case (st_q)
            TBD_IDLE:
            begin
               lamp_q <= 1'b0;
               if (err_q)
               begin
                  st_q   <= TBD_START;
                  cnt_q  <= 8'(2 * START_FLASHES - 1);
                  tmr_q  <= FAST_CNT;
                  lamp_q <= 1'b1;
               end
            end
            TBD_START:
            begin
               tmr_q <= FAST_CNT;
               if (cnt_q == 8'h00)
               begin
                  st_q   <= TBD_CODE;
                  cnt_q  <= {code_q, 1'b0} - 8'h01;
                  lamp_q <= 1'b1;
                  tmr_q  <= SLOW_CNT;
               end
               else
               begin
                  cnt_q  <= cnt_q - 8'h01;
                  lamp_q <= !lamp_q;
               end
            end
            TBD_CODE, TBD_ARG:
            begin
               tmr_q <= SLOW_CNT;
               if (cnt_q == 8'h00)
               begin
                  lamp_q <= 1'b0;
                  st_q   <= (st_q == TBD_CODE) ? TBD_PAUSE : TBD_GAP;
                  tmr_q  <= PAUSE_CNT;
               end
               else
               begin
                  cnt_q  <= cnt_q - 8'h01;
                  lamp_q <= !lamp_q;
               end
            end
            TBD_PAUSE:
            begin
               if (arg_q == 8'h00)
               begin
                  st_q <= TBD_GAP;
                  tmr_q <= PAUSE_CNT;
               end
               else
               begin
                  st_q   <= TBD_ARG;
                  cnt_q  <= 8'({arg_q, 1'b0} - 9'h001);
                  lamp_q <= 1'b1;
                  tmr_q  <= SLOW_CNT;
               end
            end
            TBD_GAP:
            begin
               st_q <= TBD_IDLE;
            end
            TBD_EMC:
            begin
               tmr_q  <= FAST_CNT;
               lamp_q <= !lamp_q;
               if (!emc_q)
                  st_q <= TBD_IDLE;
            end
            default:
            begin
               st_q <= TBD_IDLE;
            end
         endcase
      end
   end
   assign err_led_o = lamp_q;

   // Expansion bus link lamp
   logic [1:0]  link_sy_q;
   logic [1:0]  act_sy_q;
   logic [23:0] act_tmr_q;
   logic [23:0] blink_q;
   logic        blink_ph_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         link_sy_q  <= 2'b00;
         act_sy_q   <= 2'b00;
         act_tmr_q  <= 24'h000000;
         blink_q    <= 24'h000000;
         blink_ph_q <= 1'b0;
         link_led_o <= 1'b0;
      end
      else
      begin
         link_sy_q <= {link_sy_q[0], xbus_link_i};
         act_sy_q  <= {act_sy_q[0], xbus_act_i};
         if (act_sy_q[1])
            act_tmr_q <= ACT_CNT;
         else if (act_tmr_q != 24'h000000)
            act_tmr_q <= act_tmr_q - 24'h000001;
         if (blink_q == 24'h000000)
         begin
            blink_q    <= FAST_CNT;
            blink_ph_q <= !blink_ph_q;
         end
         else
            blink_q <= blink_q - 24'h000001;
         if (!link_sy_q[1])
            link_led_o <= 1'b0;
         else if (act_tmr_q != 24'h000000)
            link_led_o <= blink_ph_q;
         else
            link_led_o <= 1'b1;
      end
   end

   // Checks
   property p_dark_idle;
      @(posedge clk_i) disable iff (rst_i) (st_q == TBD_IDLE && !err_q && !emc_q) |=> !err_led_o;
   endproperty
   a_dark_idle: assert property (p_dark_idle) else $error("fault lamp lit without error");

   property p_start_order;
      @(posedge clk_i) disable iff (rst_i) (st_q == TBD_START && $changed(st_q)) |-> $past(st_q) == TBD_IDLE;
   endproperty
   a_start_order: assert property (p_start_order) else $error("start burst out of order");

   property p_code_after_start;
      @(posedge clk_i) disable iff (rst_i) (st_q == TBD_CODE && $changed(st_q)) |-> $past(st_q) == TBD_START;
   endproperty
   a_code_after_start: assert property (p_code_after_start) else $error("code not after start");

   property p_cmd_code;
      @(posedge clk_i) disable iff (rst_i) (ev_cmd_err_i && !err_q) |=> (code_q == CODE_CMD && arg_q == 8'h00);
   endproperty
   a_cmd_code: assert property (p_cmd_code) else $error("command error code wrong");

   property p_len_code;
      @(posedge clk_i) disable iff (rst_i)
         (ev_len_err_i && !err_q && !ev_cmd_err_i && !ev_data_err_i && !ev_reg_err_i && !ev_init_err_i
          && !ev_int_err_i && !ev_int_alt_i) |=> (code_q == CODE_LEN && state_word[ST_LEN_ERR]);
   endproperty
   a_len_code: assert property (p_len_code) else $error("length error code wrong");

   property p_run_lamp;
      @(posedge clk_i) disable iff (rst_i) run_led_o |-> $past(fieldbus_run_i) && !$past(err_q);
   endproperty
   a_run_lamp: assert property (p_run_lamp) else $error("run lamp lit during fault");

   property p_reserved;
      @(posedge clk_i) disable iff (rst_i) (state_word[7:3] == 5'h00) && (state_word[14:12] == 3'h0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved status bits set");

   property p_reset_clear;
      @(posedge clk_i) disable iff (rst_i) (reset_req && err_q && !sticky_q && !new_err) |=> !err_q ##0 bus_restart_o;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset request did not clear");

   property p_link_off;
      @(posedge clk_i) disable iff (rst_i) !link_sy_q[1] |=> !link_led_o;
   endproperty
   a_link_off: assert property (p_link_off) else $error("link lamp lit unconnected");

   property p_sticky;
      @(posedge clk_i) disable iff (rst_i) (sticky_q && err_q && !por_i) |=> err_q;
   endproperty
   a_sticky: assert property (p_sticky) else $error("latched fault cleared");

   c_code_seq: cover property (@(posedge clk_i) disable iff (rst_i) st_q == TBD_PAUSE ##1 st_q == TBD_ARG);
   c_emc:      cover property (@(posedge clk_i) disable iff (rst_i) st_q == TBD_EMC);
   c_reset:    cover property (@(posedge clk_i) disable iff (rst_i) err_q ##1 !err_q);
endmodule // tbd_diag

/* File: tbd_pkg.sv */
// Package for the terminal bus diagnostic lamp and status block
package tbd_pkg;
   // Clock and flash timing
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned FAST_HALF_MS    = 50;
   localparam int unsigned SLOW_HALF_MS    = 250;
   localparam int unsigned PAUSE_MS        = 1000;
   localparam int unsigned FAST_HALF_CYC   = (CLK_HZ / 1000) * FAST_HALF_MS;
   localparam int unsigned SLOW_HALF_CYC   = (CLK_HZ / 1000) * SLOW_HALF_MS;
   localparam int unsigned PAUSE_CYC       = (CLK_HZ / 1000) * PAUSE_MS;
   localparam int unsigned START_FLASHES   = 8;
   localparam int unsigned ACT_HOLD_MS     = 100;
   localparam int unsigned ACT_HOLD_CYC    = (CLK_HZ / 1000) * ACT_HOLD_MS;

   // Register map
   localparam logic [3:0]  ADDR_STATE      = 4'h0;
   localparam logic [3:0]  ADDR_CTRL       = 4'h4;
   localparam logic [3:0]  ADDR_CODE       = 4'h8;
   localparam logic [15:0] STATE_RESET     = 16'h0100;
   localparam int unsigned CTRL_RESET_BIT  = 0;

   // Status word bit positions
   localparam int unsigned ST_BUS_ERR      = 0;
   localparam int unsigned ST_CFG_CHG      = 1;
   localparam int unsigned ST_LEN_ERR      = 2;
   localparam int unsigned ST_NO_INPUTS    = 8;
   localparam int unsigned ST_IN_PEND      = 9;
   localparam int unsigned ST_OUT_PEND     = 10;
   localparam int unsigned ST_WDOG         = 11;
   localparam int unsigned ST_ACYCLIC      = 15;

   // Error codes
   localparam logic [3:0]  CODE_CMD        = 4'h3;
   localparam logic [3:0]  CODE_DATA       = 4'h4;
   localparam logic [3:0]  CODE_REG        = 4'h5;
   localparam logic [3:0]  CODE_INT        = 4'h6;
   localparam logic [3:0]  CODE_LEN        = 4'h7;
   localparam logic [7:0]  ARG_INT_DATA    = 8'h01;
   localparam logic [7:0]  ARG_INT_DATA2   = 8'h08;

   typedef enum logic [2:0] {
      TBD_IDLE  = 3'b000,
      TBD_START = 3'b001,
      TBD_CODE  = 3'b010,
      TBD_PAUSE = 3'b011,
      TBD_ARG   = 3'b100,
      TBD_GAP   = 3'b101,
      TBD_EMC   = 3'b110
   } tbd_state_e;
endpackage
